// File: ppc_pkg.sv
/*
  Shared constants and types for the power-management capability register bank.
  Assumes a simple config-space access port driven by same-clock logic.
*/
package ppc_pkg;
  localparam logic [7:0] PPC_CAP_PTR_OFFSET = 8'h34;
  localparam logic [7:0] PPC_CAP_PTR_VALUE = 8'h44;
  localparam logic [7:0] PPC_CAP_LIST_OFFSET = 8'h44;
  localparam logic [7:0] PPC_PM_CAPS_OFFSET = 8'h46;
  localparam logic [7:0] PPC_GEN_CTL_OFFSET = 8'h4C;
  localparam logic [7:0] PPC_NEXT_ITEM = 8'h00;
  localparam logic [7:0] PPC_LIST_ENTRY_TYPE = 8'h01;
  localparam int PPC_GEN_CTL_COLD_BIT = 4;
  localparam logic [3:0] PPC_WAKE_SOURCES = 4'hF;
  localparam logic [2:0] PPC_AUX_NONE = 3'h0;
  localparam logic [2:0] PPC_AUX_55MA = 3'h1;
  localparam logic [2:0] PPC_SPEC_REV = 3'h2;
  localparam logic [15:0] PPC_CAP_LIST_RESET = 16'h0001;
  localparam logic [15:0] PPC_PM_CAPS_RESET = 16'h7E02;

  typedef struct packed {
    logic wake_from_cold_off;
    logic [3:0] wake_source_states;
    logic deep_sleep_state_supported;
    logic light_sleep_state_supported;
    logic [2:0] aux_current;
    logic dev_specific_init;
    logic reserved_zero;
    logic wake_needs_bus_clock;
    logic [2:0] power_spec_revision;
  } ppc_pm_caps_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [15:0] wdata;
  } ppc_cfg_req_t;
endpackage

// File: ppc_caps_encode.sv
/*
  Builds the capabilities word from the cold-wake control bit.
  Assumes the control bit is already on the bank clock.
*/
`timescale 1ns/1ps
module ppc_caps_encode
  import ppc_pkg::*;
(
  // Control
  input wire logic cold_wake_enable_ctl_in,
  // Word
  output ppc_pkg::ppc_pm_caps_t caps_out
);
  always_comb begin
    caps_out.wake_from_cold_off = cold_wake_enable_ctl_in;
    caps_out.wake_source_states = PPC_WAKE_SOURCES;
    caps_out.deep_sleep_state_supported = 1'b1;
    caps_out.light_sleep_state_supported = 1'b1;
    caps_out.aux_current = cold_wake_enable_ctl_in ? PPC_AUX_55MA : PPC_AUX_NONE;
    caps_out.dev_specific_init = 1'b0;
    caps_out.reserved_zero = 1'b0;
    caps_out.wake_needs_bus_clock = 1'b0;
    caps_out.power_spec_revision = PPC_SPEC_REV;
  end
endmodule

// File: ppc_cap_regs.sv
/*
  Capability pointer, capability list entry, capabilities word and the
  cold-wake control bit of the general control byte.
  Assumes requests come from same-clock config logic, one per cycle at most.
*/
`timescale 1ns/1ps
// How it works
// - Next-item byte of the list word always reads zero.
// - Entry-type byte of the list word always reads 01h.
// - Capabilities bit 15 follows general control bit 4.
// - Bit 15 set advertises wake from cold-off state.
// - Wake source field bits 14..11 reads 1111b.
// - Bit 10 fixed one: deep sleep state supported.
// - Bit 9 fixed one: light sleep state supported.
// - Aux current reads 000b with bit 15 clear, 001b when set.
// - Bit 5 reads zero: no special initialization needed.
// - Reserved bit 4 always reads zero.
// - Bit 3 reads zero: wake needs no bus clock.
// - Bits 2..0 read 010b: spec revision 1.1.
// - Capabilities pointer at 34h reads fixed 44h.
// - General control bit 4 is writable and drives bit 15.
module ppc_cap_regs
  import ppc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // Config access
  input ppc_pkg::ppc_cfg_req_t cfg_req_in,
  // Read answer
  output logic [15:0] cfg_rdata_out,
  output logic cfg_rvalid_out,
  // State
  output logic cold_wake_enable_ctl_out
);
  import ppc_pkg::*;

  logic cold_wake_enable_ctl;
  ppc_pm_caps_t caps;
  logic hit_ptr;
  logic hit_list;
  logic hit_caps;
  logic hit_ctl;
  logic wr_ctl;
  logic [15:0] list_word;
  logic [15:0] next_rdata;
  logic hit_any;
  logic [15:0] caps_word;

  assign hit_ptr = cfg_req_in.addr == PPC_CAP_PTR_OFFSET;
  assign hit_list = cfg_req_in.addr == PPC_CAP_LIST_OFFSET;
  assign hit_caps = cfg_req_in.addr == PPC_PM_CAPS_OFFSET;
  assign hit_ctl = cfg_req_in.addr == PPC_GEN_CTL_OFFSET;
  // Only the control byte is writable; other hits drop writes
  assign wr_ctl = cfg_req_in.wr && hit_ctl;
  assign list_word = {PPC_NEXT_ITEM, PPC_LIST_ENTRY_TYPE};
  assign hit_any = hit_ptr || hit_list || hit_caps || hit_ctl;

  ppc_caps_encode u_enc (
    .cold_wake_enable_ctl_in(cold_wake_enable_ctl),
    .caps_out(caps)
  );

  // Flat copy keeps every arm of the read mux one plain width
  assign caps_word = caps;
  // Unmapped offsets read zero
  assign next_rdata = hit_ptr ? {8'h00, PPC_CAP_PTR_VALUE} :
                      hit_list ? list_word :
                      hit_caps ? caps_word :
                      hit_ctl ? {11'h000, cold_wake_enable_ctl, 4'h0} :
                      16'h0000;

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      cold_wake_enable_ctl <= 1'b0;
    end else if (wr_ctl) begin
      cold_wake_enable_ctl <= cfg_req_in.wdata[PPC_GEN_CTL_COLD_BIT];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      cfg_rdata_out <= 16'h0000;
      cfg_rvalid_out <= 1'b0;
    end else begin
      cfg_rvalid_out <= cfg_req_in.rd;
      cfg_rdata_out <= cfg_req_in.rd ? next_rdata : cfg_rdata_out;
    end
  end

  assign cold_wake_enable_ctl_out = cold_wake_enable_ctl;

  property p_list_fixed;
    @(posedge sys_clk_in) disable iff (reset_in)
      cfg_req_in.rd && hit_list |=> cfg_rvalid_out && cfg_rdata_out == 16'h0001;
  endproperty
  a_list_fixed: assert property (p_list_fixed) else $error("list word wrong");

  property p_type_byte;
    @(posedge sys_clk_in) disable iff (reset_in)
      cfg_req_in.rd && hit_list |=> cfg_rdata_out[7:0] == 8'h01;
  endproperty
  a_type_byte: assert property (p_type_byte) else $error("entry type wrong");

  property p_cold_follow;
    @(posedge sys_clk_in) disable iff (reset_in)
      cfg_req_in.rd && hit_caps |=> cfg_rdata_out[15] == $past(cold_wake_enable_ctl);
  endproperty
  a_cold_follow: assert property (p_cold_follow) else $error("bit 15 mismatch");

  property p_fixed_fields;
    @(posedge sys_clk_in) disable iff (reset_in)
      cfg_req_in.rd && hit_caps |=> cfg_rdata_out[14:9] == 6'h3F && cfg_rdata_out[5:0] == 6'h02;
  endproperty
  a_fixed_fields: assert property (p_fixed_fields)
    else $error("fixed field wrong");

  property p_aux;
    @(posedge sys_clk_in) disable iff (reset_in)
      cfg_req_in.rd && hit_caps |=>
        cfg_rdata_out[8:6] == (cfg_rdata_out[15] ? 3'h1 : 3'h0);
  endproperty
  a_aux: assert property (p_aux) else $error("aux current wrong");

  property p_ptr;
    @(posedge sys_clk_in) disable iff (reset_in)
      cfg_req_in.rd && hit_ptr |=> cfg_rdata_out == 16'h0044;
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer wrong");

  sequence s_ctl_write;
    cfg_req_in.wr && hit_ctl;
  endsequence
  property p_ctl_write;
    @(posedge sys_clk_in) disable iff (reset_in)
      s_ctl_write |=> cold_wake_enable_ctl == $past(cfg_req_in.wdata[4]);
  endproperty
  a_ctl_write: assert property (p_ctl_write) else $error("control write lost");

  property p_ro_write;
    @(posedge sys_clk_in) disable iff (reset_in)
      cfg_req_in.wr && !hit_ctl |=> $stable(cold_wake_enable_ctl);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only write changed state");

  // Answer comes exactly one edge after a read, and only then
  property p_rvalid_on_read;
    @(posedge sys_clk_in) disable iff (reset_in)
      cfg_req_in.rd |=> cfg_rvalid_out;
  endproperty
  a_rvalid_on_read: assert property (p_rvalid_on_read) else $error("read not answered");

  property p_rvalid_quiet;
    @(posedge sys_clk_in) disable iff (reset_in)
      !cfg_req_in.rd |=> !cfg_rvalid_out;
  endproperty
  a_rvalid_quiet: assert property (p_rvalid_quiet) else $error("answer without read");

  // Read data stands until the next read
  property p_rdata_hold;
    @(posedge sys_clk_in) disable iff (reset_in)
      !cfg_req_in.rd |=> $stable(cfg_rdata_out);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");

  // Checked through reset, so no disable here
  property p_reset_clear;
    @(posedge sys_clk_in)
      reset_in |=> !cfg_rvalid_out && cfg_rdata_out == 16'h0000 && !cold_wake_enable_ctl;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset left state behind");

  property p_ctl_byte;
    @(posedge sys_clk_in) disable iff (reset_in)
      cfg_req_in.rd && hit_ctl |=>
        cfg_rdata_out == {11'h000, $past(cold_wake_enable_ctl), 4'h0};
  endproperty
  a_ctl_byte: assert property (p_ctl_byte) else $error("control byte read wrong");

  property p_caps_clear;
    @(posedge sys_clk_in) disable iff (reset_in)
      cfg_req_in.rd && hit_caps && !cold_wake_enable_ctl |=>
        cfg_rdata_out == PPC_PM_CAPS_RESET;
  endproperty
  a_caps_clear: assert property (p_caps_clear) else $error("caps word wrong, wake off");

  property p_caps_set;
    @(posedge sys_clk_in) disable iff (reset_in)
      cfg_req_in.rd && hit_caps && cold_wake_enable_ctl |=>
        cfg_rdata_out == (PPC_PM_CAPS_RESET | 16'h8000 | {7'h00, PPC_AUX_55MA, 6'h00});
  endproperty
  a_caps_set: assert property (p_caps_set) else $error("caps word wrong, wake on");

  property p_unmapped_zero;
    @(posedge sys_clk_in) disable iff (reset_in)
      cfg_req_in.rd && !hit_any |=> cfg_rdata_out == 16'h0000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

  // Any cycle without a control write keeps the bit
  property p_ctl_hold;
    @(posedge sys_clk_in) disable iff (reset_in)
      !(cfg_req_in.wr && hit_ctl) |=> $stable(cold_wake_enable_ctl);
  endproperty
  a_ctl_hold: assert property (p_ctl_hold) else $error("control bit moved unasked");

  // Read and write in one cycle: read sees the old bit
  property p_rd_wr_same;
    @(posedge sys_clk_in) disable iff (reset_in)
      cfg_req_in.rd && cfg_req_in.wr && hit_ctl |=>
        cfg_rdata_out[4] == $past(cold_wake_enable_ctl) &&
        cold_wake_enable_ctl == $past(cfg_req_in.wdata[PPC_GEN_CTL_COLD_BIT]);
  endproperty
  a_rd_wr_same: assert property (p_rd_wr_same) else $error("read-write order wrong");

  sequence s_caps_read;
    cfg_req_in.rd && hit_caps;
  endsequence
  sequence s_write_then_caps_read;
    s_ctl_write ##1 !cfg_req_in.wr ##1 s_caps_read;
  endsequence
  // Bit 15 follows a control write seen two edges before the read
  property p_wake_after_write;
    @(posedge sys_clk_in) disable iff (reset_in)
      s_write_then_caps_read |=>
        cfg_rdata_out[15] == $past(cfg_req_in.wdata[PPC_GEN_CTL_COLD_BIT], 3);
  endproperty
  a_wake_after_write: assert property (p_wake_after_write)
    else $error("control write not seen in caps word");
endmodule

// File: ppc_host_model.sv
/*
  Host bridge model issuing config reads and writes.
  Assumes the bank answers a read on the next cycle.
*/
`timescale 1ns/1ps
module ppc_host_model
  import ppc_pkg::*;
(
  // Clock
  input wire logic sys_clk_in,
  // Bank side
  output ppc_pkg::ppc_cfg_req_t cfg_req_out,
  input wire logic [15:0] cfg_rdata_in,
  input wire logic cfg_rvalid_in
);
  initial cfg_req_out = '{1'b0, 1'b0, 8'hFF, 16'hFFFF};
  // Released lines invert so stale values never pass
  task automatic access(input logic r, input logic w, input logic [7:0] a,
                        input logic [15:0] d, output logic [15:0] q, output logic v);
    @(posedge sys_clk_in) #1;
    cfg_req_out = '{r, w, a, d};
    @(posedge sys_clk_in) #1;
    v = cfg_rvalid_in;
    q = cfg_rdata_in;
    cfg_req_out = '{1'b0, 1'b0, ~a, ~d};
  endtask
endmodule

// File: test_pci_pm_capability_regs.sv
/*
  Testbench for the capability register bank.
  Assumes the host model carries all config traffic.
*/
`timescale 1ns/1ps
module test_pci_pm_capability_regs;
  import ppc_pkg::*;
  logic sys_clk_in = 1'b0;
  logic reset_in = 1'b1;
  ppc_cfg_req_t req;
  logic [15:0] rdata;
  logic [15:0] q;
  logic rvalid;
  logic ctl;
  logic v;
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;
  always #4 sys_clk_in = ~sys_clk_in;
  ppc_cap_regs dut (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .cfg_req_in(req),
    .cfg_rdata_out(rdata), .cfg_rvalid_out(rvalid), .cold_wake_enable_ctl_out(ctl));
  ppc_host_model host (.sys_clk_in(sys_clk_in), .cfg_req_out(req), .cfg_rdata_in(rdata),
    .cfg_rvalid_in(rvalid));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    host.access(1'b1, 1'b0, a, 16'h0000, q, v);
    check("rvalid", {15'h0000, v}, 16'h0001);
    check($sformatf("word %h", a), q, exp);
  endtask
  // A write must not raise the read answer
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    host.access(1'b0, 1'b1, a, d, q, v);
    check("rvalid on write", {15'h0000, v}, 16'h0000);
  endtask
  task automatic summarize();
    $display("Checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      summarize();
    end
  end
  initial begin
    repeat (4) @(posedge sys_clk_in);
    #1 reset_in = 1'b0;
    check("reset ctl", {15'h0000, ctl}, 16'h0000);
    rd(8'h34, 16'h0044);
    rd(8'h44, 16'h0001);
    rd(8'h46, 16'h7E02);
    wr(8'h44, 16'hFFFE);
    wr(8'h46, 16'h81FD);
    rd(8'h44, 16'h0001);
    rd(8'h46, 16'h7E02);
    wr(8'h4C, 16'hFFFF);
    check("ctl set", {15'h0000, ctl}, 16'h0001);
    rd(8'h4C, 16'h0010);
    rd(8'h46, 16'hFE42);
    wr(8'h4C, 16'hFFEF);
    rd(8'h46, 16'h7E02);
    host.access(1'b1, 1'b1, 8'h4C, 16'hFFFF, q, v);
    check("rvalid on rd-wr", {15'h0000, v}, 16'h0001);
    check("ctl byte on rd-wr", q, 16'h0000);
    check("ctl after rd-wr", {15'h0000, ctl}, 16'h0001);
    rd(8'h46, 16'hFE42);
    reset_in = 1'b1;
    repeat (2) @(posedge sys_clk_in);
    #1 reset_in = 1'b0;
    check("mid reset ctl", {15'h0000, ctl}, 16'h0000);
    check("mid reset rvalid", {15'h0000, rvalid}, 16'h0000);
    check("mid reset rdata", rdata, 16'h0000);
    rd(8'h46, 16'h7E02);
    rd(8'h50, 16'h0000);
    summarize();
  end
endmodule
